// >>> hw/analog_input_diag_status.sv
// diagnostic records, interrupt data word and value substitution for an
// eight-channel analog input module, reached over axi4-lite
// assumes the converter hands over one synchronous cycle as a one-clock strobe
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module analog_input_diag_status
  import aidiag_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [aidiag_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [aidiag_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire aidiag_pkg::conv_cycle_t conv,
  input wire logic supply_missing,
  input wire logic internal_fault,
  input wire logic irq_ack,
  output logic process_irq,
  output logic diag_coming,
  output logic diag_going
);
  import aidiag_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  logic [31:0] cfg_q;
  logic [NUM_CH-1:0] over_q;
  logic [NUM_CH-1:0] under_q;
  logic [NUM_CH-1:0] param_q;
  logic [7:0] irq_upper_q;
  logic [7:0] irq_lower_q;
  logic [7:0] irq_cycle_q;
  logic [7:0] irq_upper_d;
  logic [7:0] irq_lower_d;
  logic [7:0] irq_cycle_d;
  logic irq_pending_q;
  logic irq_lost_q;
  logic supply_q;
  logic internal_q;
  logic [15:0] value_q [NUM_CH];
  logic wr_ok;
  logic lost_clear;

  // ************************************************************
  // configuration decode
  // ************************************************************
  wire [NUM_CH-1:0] diag_en = cfg_q[CFG_DIAG_EN_LSB +: NUM_CH];
  wire irq_over_en = cfg_q[CFG_IRQ_OVER_EN];
  wire irq_under_en = cfg_q[CFG_IRQ_UNDER_EN];
  wire irq_cycle_en = cfg_q[CFG_IRQ_CYCLE_EN];
  wire fifo_mode = cfg_q[CFG_FIFO_MODE];

  // ************************************************************
  // diagnostic record assembly
  // ************************************************************
  // only channels whose diagnostics are enabled report errors
  wire [NUM_CH-1:0] ch_over = over_q & diag_en;
  wire [NUM_CH-1:0] ch_under = under_q & diag_en;
  wire [NUM_CH-1:0] ch_param = param_q & diag_en;
  wire [NUM_CH-1:0] ch_err_map = ch_over | ch_under | ch_param;
  wire any_ch_err = |ch_err_map;
  wire any_param = |ch_param;
  wire supply_err = supply_q & (|diag_en);
  wire internal_err = internal_q & (|diag_en);
  wire external_err = any_ch_err | supply_err;
  wire module_err = any_ch_err | supply_err | internal_err;

  logic [7:0] summary_byte;
  always_comb begin
    summary_byte = 8'h00;
    summary_byte[SUM_MODULE_ERR] = module_err;
    summary_byte[SUM_INTERNAL_ERR] = internal_err;
    summary_byte[SUM_EXTERNAL_ERR] = external_err;
    summary_byte[SUM_CHANNEL_ERR] = any_ch_err;
    summary_byte[SUM_NO_SUPPLY] = supply_err;
    summary_byte[SUM_BAD_PARAM] = any_param;
  end

  wire [7:0] class_byte = {3'b000, 1'b1, CLASS_ANALOG};
  wire [7:0] lost_byte = {1'b0, irq_lost_q, 6'b000000};
  wire [7:0] chtype_byte = {1'b0, CHTYPE_ANALOG_IN};

  function automatic logic [7:0] detail_byte(input logic p, input logic u, input logic o);
    detail_byte = {o, u, 5'b00000, p};
  endfunction

  // ************************************************************
  // diagnostic interrupt: coming and going
  // ************************************************************
  aidiag_event_edge u_diag_edge (
    .clock(clock),
    .rst(rst),
    .enable(|diag_en),
    .level(module_err),
    .coming(diag_coming),
    .going(diag_going)
  );

  // ************************************************************
  // conversion capture and process interrupt data
  // ************************************************************
  wire irq_allowed = ~fifo_mode;
  wire [7:0] hit_upper = irq_over_en ? conv.upper_limit : 8'h00;
  wire [7:0] hit_lower = irq_under_en ? conv.lower_limit : 8'h00;
  wire hit_cycle = irq_cycle_en;
  wire new_event = conv.valid & irq_allowed & ((|hit_upper) | (|hit_lower) | hit_cycle);

  always_comb begin
    irq_upper_d = irq_upper_q;
    irq_lower_d = irq_lower_q;
    irq_cycle_d = irq_cycle_q;
    if (irq_ack) begin
      irq_upper_d = 8'h00;
      irq_lower_d = 8'h00;
      irq_cycle_d = 8'h00;
    end
    // a new event wins over the acknowledge in the same cycle
    if (new_event && (!irq_pending_q || irq_ack)) begin
      irq_upper_d = hit_upper;
      irq_lower_d = hit_lower;
      irq_cycle_d = {4'h0, hit_cycle, 3'b000};
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_upper_q <= 8'h00;
      irq_lower_q <= 8'h00;
      irq_cycle_q <= 8'h00;
      irq_pending_q <= 1'b0;
      irq_lost_q <= 1'b0;
    end else begin
      irq_upper_q <= irq_upper_d;
      irq_lower_q <= irq_lower_d;
      irq_cycle_q <= irq_cycle_d;
      irq_pending_q <= new_event | (irq_pending_q & ~irq_ack);
      // an event while the previous one is still unacknowledged is lost
      if (new_event && irq_pending_q && !irq_ack) begin
        irq_lost_q <= 1'b1;
      end else if (lost_clear) begin
        irq_lost_q <= 1'b0;
      end
    end
  end

  assign process_irq = irq_pending_q;

  // ************************************************************
  // per-channel status and measured values
  // ************************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      over_q <= 8'h00;
      under_q <= 8'h00;
      param_q <= 8'h00;
      supply_q <= 1'b0;
      internal_q <= 1'b0;
    end else begin
      supply_q <= supply_missing;
      internal_q <= internal_fault;
      if (conv.valid) begin
        over_q <= conv.over;
        under_q <= conv.under;
        param_q <= conv.param_err;
      end
    end
  end

  // values are kept as signed 16-bit words, sign in bit 15
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        value_q[i] <= 16'h0000;
      end
    end else if (conv.valid) begin
      for (int i = 0; i < NUM_CH; i++) begin
        value_q[i] <= clamp_value(conv.raw[i*16 +: 16], conv.over[i], conv.under[i],
                                  conv.param_err[i] | supply_missing);
      end
    end
  end

  // ************************************************************
  // register bus
  // ************************************************************
  logic wr_stb;
  logic [5:0] wr_idx;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [5:0] rd_idx;
  rd_answer_t rd_answer;

  aidiag_axil_slave u_bus (
    .clock(clock),
    .rst(rst),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wr_stb(wr_stb),
    .wr_idx(wr_idx),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_idx(rd_idx),
    .rd_answer(rd_answer)
  );

  wire wr_cfg = wr_stb & (wr_idx == 6'(IDX_CFG));
  assign wr_ok = (wr_idx == 6'(IDX_CFG)) | (wr_idx == 6'(IDX_STATUS));
  // writing a one to bit 6 of the status word clears the lost flag
  assign lost_clear = wr_stb & (wr_idx == 6'(IDX_STATUS)) & wr_strb[0] & wr_data[LOST_BIT];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg_q <= CFG_RESET;
    end else if (wr_cfg) begin
      for (int b = 0; b < 4; b++) begin
        if (wr_strb[b]) begin
          cfg_q[b*8 +: 8] <= wr_data[b*8 +: 8];
        end
      end
    end
  end

  // read mux: record bytes sit in the low byte of each word
  always_comb begin
    rd_answer.resp = RESP_OKAY;
    rd_answer.data = 32'h0000_0000;
    if (rd_idx >= 6'(IDX_DETAIL0) && rd_idx <= 6'(IDX_DETAIL7)) begin
      rd_answer.data[7:0] = detail_byte(ch_param[rd_idx[2:0]], ch_under[rd_idx[2:0]],
                                        ch_over[rd_idx[2:0]]);
    end else if (rd_idx >= 6'(IDX_VALUE0) && rd_idx <= 6'(IDX_VALUE7)) begin
      rd_answer.data[15:0] = value_q[rd_idx[2:0]];
    end else begin
      case (rd_idx)
        6'(IDX_SUMMARY): rd_answer.data[7:0] = summary_byte;
        6'(IDX_CLASS): rd_answer.data[7:0] = class_byte;
        6'(IDX_RSVD2): rd_answer.data[7:0] = 8'h00;
        6'(IDX_LOST): rd_answer.data[7:0] = lost_byte;
        6'(IDX_CHTYPE): rd_answer.data[7:0] = chtype_byte;
        6'(IDX_BITS_PER_CH): rd_answer.data[7:0] = BITS_PER_CH;
        6'(IDX_CH_COUNT): rd_answer.data[7:0] = CH_COUNT;
        6'(IDX_ERR_MAP): rd_answer.data[7:0] = ch_err_map;
        6'(IDX_IRQ_UPPER): rd_answer.data[7:0] = irq_upper_q;
        6'(IDX_IRQ_LOWER): rd_answer.data[7:0] = irq_lower_q;
        6'(IDX_IRQ_CYCLE): rd_answer.data[7:0] = irq_cycle_q;
        6'(IDX_IRQ_RSVD): rd_answer.data[7:0] = 8'h00;
        6'(IDX_CFG): rd_answer.data = cfg_q;
        6'(IDX_STATUS): rd_answer.data = {29'h0, fifo_mode, irq_pending_q, irq_lost_q};
        default: rd_answer.resp = RESP_SLVERR;
      endcase
    end
  end
endmodule

// >>> common/aidiag_pkg.sv
// package for the analog input diagnostic and process interrupt status block
// assumes a single 250 mhz clock domain and an axi4-lite register bus
package aidiag_pkg;

  // ************************************************************
  // register indices (printed offsets are byte indices, so address = 4 * index)
  // ************************************************************
  localparam int unsigned IDX_SUMMARY = 0;
  localparam int unsigned IDX_CLASS = 1;
  localparam int unsigned IDX_RSVD2 = 2;
  localparam int unsigned IDX_LOST = 3;
  localparam int unsigned IDX_CHTYPE = 4;
  localparam int unsigned IDX_BITS_PER_CH = 5;
  localparam int unsigned IDX_CH_COUNT = 6;
  localparam int unsigned IDX_ERR_MAP = 7;
  localparam int unsigned IDX_DETAIL0 = 8;
  localparam int unsigned IDX_DETAIL7 = 15;
  localparam int unsigned IDX_IRQ_UPPER = 16;
  localparam int unsigned IDX_IRQ_LOWER = 17;
  localparam int unsigned IDX_IRQ_CYCLE = 18;
  localparam int unsigned IDX_IRQ_RSVD = 19;
  localparam int unsigned IDX_CFG = 20;
  localparam int unsigned IDX_STATUS = 21;
  localparam int unsigned IDX_VALUE0 = 24;
  localparam int unsigned IDX_VALUE7 = 31;

  localparam int unsigned ADDR_W = 8;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int unsigned SUM_MODULE_ERR = 0;
  localparam int unsigned SUM_INTERNAL_ERR = 1;
  localparam int unsigned SUM_EXTERNAL_ERR = 2;
  localparam int unsigned SUM_CHANNEL_ERR = 3;
  localparam int unsigned SUM_NO_SUPPLY = 4;
  localparam int unsigned SUM_BAD_PARAM = 7;
  localparam int unsigned LOST_BIT = 6;
  localparam int unsigned DET_PARAM = 0;
  localparam int unsigned DET_UNDER = 6;
  localparam int unsigned DET_OVER = 7;
  localparam int unsigned CYCLE_END_BIT = 3;

  // configuration register fields
  localparam int unsigned CFG_DIAG_EN_LSB = 0;
  localparam int unsigned CFG_IRQ_OVER_EN = 8;
  localparam int unsigned CFG_IRQ_UNDER_EN = 9;
  localparam int unsigned CFG_IRQ_CYCLE_EN = 10;
  localparam int unsigned CFG_FIFO_MODE = 11;

  // ************************************************************
  // constant values and reset values
  // ************************************************************
  localparam int unsigned NUM_CH = 8;
  localparam logic [3:0] CLASS_ANALOG = 4'h5;
  localparam int unsigned CLASS_CH_INFO = 4;
  localparam logic [7:0] CLASS_RESET = 8'h15;
  localparam logic [6:0] CHTYPE_ANALOG_IN = 7'h71;
  localparam logic [7:0] BITS_PER_CH = 8'h08;
  localparam logic [7:0] CH_COUNT = 8'h08;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [15:0] VALUE_HIGH = 16'h7fff;
  localparam logic [15:0] VALUE_LOW = 16'h8000;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic valid;
    logic [NUM_CH-1:0] over;
    logic [NUM_CH-1:0] under;
    logic [NUM_CH-1:0] param_err;
    logic [NUM_CH-1:0] upper_limit;
    logic [NUM_CH-1:0] lower_limit;
    logic [NUM_CH*16-1:0] raw;
  } conv_cycle_t;

  typedef struct packed {
    logic [31:0] data;
    logic [1:0] resp;
  } rd_answer_t;

  // channel value clamp shared by the value path
  function automatic logic [15:0] clamp_value(input logic [15:0] raw, input logic over,
                                              input logic under, input logic force_high);
    if (over || force_high) begin
      clamp_value = VALUE_HIGH;
    end else if (under) begin
      clamp_value = VALUE_LOW;
    end else begin
      clamp_value = raw;
    end
  endfunction

endpackage

// >>> hw/aidiag_event_edge.sv
// coming and going detector for the diagnostic condition
// assumes the condition is a level synchronous to clock
`timescale 1ns/1ps
module aidiag_event_edge (
  input wire logic clock,
  input wire logic rst,
  input wire logic enable,
  input wire logic level,
  output logic coming,
  output logic going
);
  logic level_q;
  logic level_d;

  // disabled diagnostics announce no error; disabling them while an error stands retracts it
  assign level_d = enable & level;
  assign coming = level_d & ~level_q;
  assign going = ~level_d & level_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      level_q <= 1'b0;
    end else begin
      level_q <= level_d;
    end
  end
endmodule

// >>> hw/aidiag_axil_slave.sv
// axi4-lite slave handshake shell: takes address and data in any order
// assumes the owner answers reads combinationally from an index
`timescale 1ns/1ps
module aidiag_axil_slave
  import aidiag_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [aidiag_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [aidiag_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic wr_stb,
  output logic [5:0] wr_idx,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  output logic [5:0] rd_idx,
  input wire aidiag_pkg::rd_answer_t rd_answer
);
  logic aw_have_q;
  logic w_have_q;
  logic [5:0] aw_idx_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q;
  logic bvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic rvalid_q;
  logic aw_take;
  logic w_take;
  logic ar_take;

  assign awready = ~aw_have_q & ~bvalid_q;
  assign wready = ~w_have_q & ~bvalid_q;
  assign arready = ~rvalid_q;
  assign aw_take = awvalid & awready;
  assign w_take = wvalid & wready;
  assign ar_take = arvalid & arready;
  assign wr_stb = aw_have_q & w_have_q & ~bvalid_q;
  assign wr_idx = aw_idx_q;
  assign wr_data = w_data_q;
  assign wr_strb = w_strb_q;
  assign rd_idx = araddr[7:2];
  assign bresp = bresp_q;
  assign bvalid = bvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign rvalid = rvalid_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_idx_q <= 6'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_have_q <= 1'b1;
        aw_idx_q <= awaddr[7:2];
      end
      if (w_take) begin
        w_have_q <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (wr_stb) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_answer.data;
      rresp_q <= rd_answer.resp;
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
    end
  end
endmodule

// >>> tb/aidiag_status_props.sv
// concurrent checks on the top ports of the diagnostic status block
// assumes one clock domain with reset rst; the bind sits at the foot of this file
`timescale 1ns/1ps
module aidiag_status_props
  import aidiag_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire aidiag_pkg::conv_cycle_t conv,
  input wire logic irq_ack,
  input wire logic process_irq,
  input wire logic diag_coming,
  input wire logic diag_going
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // ************************************************************
  // bus answers
  // ************************************************************
  chk_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer missing");
  chk_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write answer missing");
  chk_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  chk_write_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  chk_read_block: assert property (rvalid |-> !arready)
    else $error("read taken while answer pending");
  // ************************************************************
  // events
  // ************************************************************
  chk_irq_source: assert property ($rose(process_irq) |-> $past(conv.valid))
    else $error("process interrupt without cycle end");
  chk_irq_pending: assert property (process_irq && !irq_ack |=> process_irq)
    else $error("process interrupt dropped");
  chk_irq_clear: assert property (irq_ack && !conv.valid |=> !process_irq)
    else $error("process interrupt not cleared");
  chk_diag_exclusive: assert property (!(diag_coming && diag_going))
    else $error("coming and going together");
  chk_coming_pulse: assert property (diag_coming |=> !diag_coming)
    else $error("coming pulse too long");
  chk_going_pulse: assert property (diag_going |=> !diag_going)
    else $error("going pulse too long");
  cover property (process_irq && irq_ack);
  cover property ($rose(diag_coming));
  cover property (bvalid && bready);
  cover property (conv.valid && process_irq);
endmodule
bind analog_input_diag_status aidiag_status_props u_props (.clock(clock), .rst(rst),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
  .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
  .rvalid(rvalid), .rready(rready), .conv(conv), .irq_ack(irq_ack),
  .process_irq(process_irq), .diag_coming(diag_coming), .diag_going(diag_going));

// >>> tb/aidiag_cpu_model.sv
// controller-side model: axi4-lite master tasks and the interrupt acknowledge
// assumes tasks are called from one process, one transfer at a time
`timescale 1ns/1ps
module aidiag_cpu_model (
  input wire logic clock,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready,
  output logic irq_ack
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, irq_ack} = '0;
  end
  // released lines show the inverse so stale values are never mistaken for live ones
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge clock);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (1) begin
      @(posedge clock);
      if (!ad && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (!wd && wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
        wdata <= ~d;
      end
      if (bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic ad;
    ad = 1'b0;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (1) begin
      @(posedge clock);
      if (!ad && arready) begin
        ad = 1'b1;
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (rvalid) begin
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic ack;
    @(posedge clock);
    irq_ack <= 1'b1;
    @(posedge clock);
    irq_ack <= 1'b0;
  endtask
endmodule

// >>> tb/test_analog_input_diag_status.sv
// self-checking bench for the diagnostic status block
// assumes the controller model drives the bus; the bench drives converter inputs
`timescale 1ns/1ps
module test_analog_input_diag_status;
  import aidiag_pkg::*;
  // channel n reads 1230h + n
  localparam logic [127:0] RAW = 128'h1237_1236_1235_1234_1233_1232_1231_1230;
  localparam logic [127:0] RST_MAP = 128'h0000_0000_0000_0000_0008_0871_0000_1500;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  conv_cycle_t conv;
  logic supply_missing, internal_fault, irq_ack, process_irq, diag_coming, diag_going;
  int err_count = 0;
  int compares = 0;
  int cycles = 0;
  int comings = 0;
  int goings = 0;
  always #2 clock = ~clock;
  analog_input_diag_status dut (.clock(clock), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .conv(conv), .supply_missing(supply_missing), .internal_fault(internal_fault),
    .irq_ack(irq_ack), .process_irq(process_irq), .diag_coming(diag_coming),
    .diag_going(diag_going));
  aidiag_cpu_model u_cpu (.clock(clock), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .irq_ack(irq_ack));
  // ************************************************************
  // helpers
  // ************************************************************
  always @(posedge clock) begin
    cycles++;
    if (diag_coming === 1'b1) comings++;
    if (diag_going === 1'b1) goings++;
    if (cycles == 20000) begin
      err_count++;
      summarize();
    end
  end
  task summarize;
    $display("err_count %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] rr;
    u_cpu.rd(a, d, rr);
    check({30'h0, rr}, {30'h0, RESP_OKAY});
    check(d, exp);
  endtask
  // the strobe lasts one clock; three further edges let the pulses and counters settle
  task send_conv(input logic [7:0] o, u, p, hi, lo);
    @(posedge clock);
    conv <= '{valid: 1'b1, over: o, under: u, param_err: p, upper_limit: hi,
      lower_limit: lo, raw: RAW};
    @(posedge clock);
    conv.valid <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task reset_values;
    logic [31:0] d;
    for (int i = 0; i < 16; i++) rchk(8'(4 * i), {24'h0, RST_MAP[8*i+:8]});
    rchk(8'h50, 32'h0);
    u_cpu.rd(8'h5c, d, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    u_cpu.wr(8'h08, 32'hff, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    rchk(8'h08, 32'h0);
  endtask
  task channel_errors;
    int c0;
    send_conv(8'h04, 8'h00, 8'h00, 8'h00, 8'h00);
    rchk(8'h1c, 32'h0);
    rchk(8'h68, 32'h7fff);
    send_conv(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    u_cpu.wr(8'h50, 32'hff, r);
    c0 = comings;
    send_conv(8'h04, 8'h20, 8'h01, 8'h00, 8'h00);
    check(32'(comings - c0), 32'h1);
    rchk(8'h00, 32'h8d);
    rchk(8'h1c, 32'h25);
    rchk(8'h20, 32'h01);
    rchk(8'h28, 32'h80);
    rchk(8'h34, 32'h40);
    rchk(8'h60, 32'h7fff);
    rchk(8'h68, 32'h7fff);
    rchk(8'h74, 32'h8000);
    rchk(8'h64, 32'h1231);
    rchk(8'h7c, 32'h1237);
    c0 = goings;
    send_conv(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    check(32'(goings - c0), 32'h1);
    rchk(8'h00, 32'h0);
  endtask
  task supply_faults;
    supply_missing <= 1'b1;
    send_conv(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    rchk(8'h00, 32'h15);
    rchk(8'h6c, 32'h7fff);
    supply_missing <= 1'b0;
    internal_fault <= 1'b1;
    send_conv(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    rchk(8'h00, 32'h03);
    internal_fault <= 1'b0;
    send_conv(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    rchk(8'h00, 32'h0);
  endtask
  task irq_case(input logic [11:0] cf, input logic [7:0] hi, lo, input logic ei,
                input logic [7:0] a, e);
    u_cpu.wr(8'h50, {20'h0, cf}, r);
    check({30'h0, r}, {30'h0, RESP_OKAY});
    send_conv(8'h00, 8'h00, 8'h00, hi, lo);
    check({31'h0, process_irq}, {31'h0, ei});
    rchk(a, {24'h0, e});
    u_cpu.ack();
    repeat (2) @(posedge clock);
    check({31'h0, process_irq}, 32'h0);
    rchk(a, 32'h0);
  endtask
  task lost_event;
    u_cpu.wr(8'h50, 32'h4ff, r);
    send_conv(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    send_conv(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    rchk(8'h0c, 32'h40);
    rchk(8'h4c, 32'h0);
    rchk(8'h54, 32'h3);
    u_cpu.wr(8'h54, 32'h40, r);
    rchk(8'h0c, 32'h0);
    u_cpu.ack();
  endtask
  initial begin
    conv = '0;
    supply_missing = 1'b0;
    internal_fault = 1'b0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    reset_values();
    channel_errors();
    supply_faults();
    irq_case(12'h1ff, 8'h00, 8'h00, 1'b0, 8'h40, 8'h00);
    irq_case(12'h1ff, 8'h81, 8'h42, 1'b1, 8'h40, 8'h81);
    irq_case(12'h2ff, 8'h81, 8'h42, 1'b1, 8'h44, 8'h42);
    irq_case(12'h4ff, 8'h00, 8'h00, 1'b1, 8'h48, 8'h08);
    irq_case(12'hfff, 8'h81, 8'h42, 1'b0, 8'h40, 8'h00);
    lost_event();
    summarize();
  end
endmodule
